// *** core/shi_fifo.sv ***
`timescale 1ns/100ps
module shi_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic    i_clk,
  input wire logic    i_sys_rst,
  shi_stream_if.buffer s
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign s.in_ready  = (cnt != FULL);
  assign s.out_valid = (cnt != '0);
  assign s.out_data  = mem[rp];
  assign push        = s.in_valid & s.in_ready;
  assign pop         = s.out_valid & s.out_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wp] <= s.in_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      end
      if (pop)
      begin
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : shi_fifo

// *** core/shi_host_port.sv ***
`timescale 1ns/100ps
module shi_host_port (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_sck,
  input  wire logic                    i_nss,
  input  wire logic                    i_mosi,
  input  wire logic [shi_pkg::NSRC-1:0] i_irq_src,
  input  wire logic                    i_clr_on_read,
  input  wire logic                    i_irq_active_high,
  output logic                         o_miso,
  output logic                         o_miso_oe,
  output logic                         o_busy,
  output logic                         o_irq,
  output logic [shi_pkg::NSRC-1:0]     o_irq_status
);
  logic [2:0]                 sync1;
  logic [2:0]                 sync2;
  logic [2:0]                 pins;
  logic                       sck;
  logic                       nss;
  logic                       mosi;
  logic                       sck_q;
  logic                       nss_q;
  logic                       sck_rise;
  logic                       sck_fall;
  logic                       sel_fall;
  logic                       sel_rise;
  logic                       rst;
  logic                       soft_rst;
  logic [2:0]                 bit_cnt;
  logic [6:0]                 shin;
  logic                       rd_frame;
  logic                       byte_done;
  logic                       eof_pend;
  logic                       push_valid;
  logic [shi_pkg::FIFO_W-1:0] push_data;
  logic                       overflow;
  logic [7:0]                 tx;
  logic [2:0]                 tx_idx;
  logic [31:0]                resp;
  logic                       resp_valid;
  shi_pkg::shi_state_type     state;
  logic [7:0]                 code;
  logic [7:0]                 addr;
  logic [31:0]                data;
  logic [shi_pkg::CNT_W-1:0]  cnt;
  logic                       pop;
  logic                       is_eof;
  logic                       exec;
  logic                       wr_ok;
  logic                       rd_ok;
  logic                       param_err;
  logic                       done;
  logic [shi_pkg::NSRC-1:0]   status;
  logic [shi_pkg::NSRC-1:0]   enable;
  logic [shi_pkg::NSRC-1:0]   set_vec;
  logic [shi_pkg::NSRC-1:0]   clr_vec;
  logic [shi_pkg::NSRC-1:0]   hold;
  logic                       pend;

  shi_stream_if #(.W(shi_pkg::FIFO_W)) fq ();

  shi_fifo #(.W(shi_pkg::FIFO_W), .D(shi_pkg::FIFO_D)) u_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (rst),
    .s         (fq.buffer)
  );

  // pins are asynchronous to i_clk: two flops each
  assign pins = {i_mosi, i_nss, i_sck};
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          sync1[g] <= (g == 1);
          sync2[g] <= (g == 1);
        end
        else
        begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  assign sck  = sync2[0];
  assign nss  = sync2[1];
  assign mosi = sync2[2];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sck_q <= 1'b0;
      nss_q <= 1'b1;
    end
    else
    begin
      sck_q <= sck;
      nss_q <= nss;
    end
  end

  // mode 0: sample on rising, shift out on falling
  assign sck_rise = sck & ~sck_q & ~nss;
  assign sck_fall = ~sck & sck_q & ~nss;
  assign sel_fall = ~nss & nss_q;
  assign sel_rise = nss & ~nss_q;
  assign rst      = i_sys_rst | soft_rst;

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      bit_cnt  <= '0;
      shin     <= '0;
      rd_frame <= 1'b0;
    end
    else if (sel_fall)
    begin
      bit_cnt  <= '0;
      rd_frame <= resp_valid;
    end
    else if (sel_rise)
    begin
      bit_cnt <= '0;
    end
    else if (sck_rise)
    begin
      shin    <= {shin[5:0], mosi};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  assign byte_done = sck_rise & (bit_cnt == 3'h7);

  // a frame end marker follows every frame's bytes
  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      eof_pend <= 1'b0;
    end
    else if (sel_rise)
    begin
      eof_pend <= 1'b1;
    end
    else if (fq.in_ready)
    begin
      eof_pend <= 1'b0;
    end
  end

  // bytes of a response frame are dummies and never stored
  always_comb
  begin
    push_valid = eof_pend;
    push_data  = {1'b1, 8'h00};
    if (byte_done && !rd_frame)
    begin
      push_valid = 1'b1;
      push_data  = {1'b0, shin, mosi};
    end
  end

  assign fq.in_valid = push_valid;
  assign fq.in_data  = push_data;
  // the link cannot be stalled, so a byte met by a full buffer is lost
  assign overflow    = byte_done & ~rd_frame & ~fq.in_ready;

  // response bytes go out low byte first, bits high first
  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      tx     <= '0;
      tx_idx <= '0;
    end
    else if (sel_fall)
    begin
      tx     <= resp_valid ? resp[7:0] : 8'h00;
      tx_idx <= 3'h1;
    end
    else if (sck_fall)
    begin
      if (bit_cnt == 3'h0)
      begin
        tx     <= (rd_frame && tx_idx < 3'(shi_pkg::RESP_BYTES)) ? 8'(resp >> {tx_idx[1:0], 3'h0}) : 8'h00;
        tx_idx <= (tx_idx == 3'(shi_pkg::RESP_BYTES)) ? tx_idx : tx_idx + 1'b1;
      end
      else
      begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  assign o_miso = tx[7];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_miso_oe <= 1'b0;
    end
    else
    begin
      o_miso_oe <= ~nss;
    end
  end

  // command parser on the drain side of the buffer
  assign fq.out_ready = (state != shi_pkg::S_EXEC);
  assign pop          = fq.out_valid & fq.out_ready;
  assign is_eof       = fq.out_data[shi_pkg::EOF_BIT];
  assign exec         = (state == shi_pkg::S_EXEC);

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      state <= shi_pkg::S_CODE;
      code  <= '0;
      addr  <= '0;
      data  <= '0;
      cnt   <= '0;
    end
    else
    begin
      case (state)
        shi_pkg::S_CODE:
        begin
          if (pop && !is_eof)
          begin
            code  <= fq.out_data[7:0];
            cnt   <= '0;
            state <= shi_pkg::S_PARAM;
          end
        end
        shi_pkg::S_PARAM:
        begin
          if (pop && is_eof)
          begin
            state <= shi_pkg::S_EXEC;
          end
          else if (pop)
          begin
            if (cnt == '0)
            begin
              addr <= fq.out_data[7:0];
            end
            else
            begin
              data <= {fq.out_data[7:0], data[31:8]};
            end
            if (cnt <= shi_pkg::CNT_W'(shi_pkg::MAX_PARAMS))
            begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        default:
        begin
          state <= shi_pkg::S_CODE;
        end
      endcase
    end
  end

  assign wr_ok = (code == shi_pkg::CMD_WRITE_REG) && (cnt == shi_pkg::CNT_W'(shi_pkg::WR_PARAMS)) &&
                 (addr == shi_pkg::ADDR_SYS_CFG || addr == shi_pkg::ADDR_IRQ_EN ||
                  addr == shi_pkg::ADDR_IRQ_CLR);
  assign rd_ok = (code == shi_pkg::CMD_READ_REG) && (cnt == shi_pkg::CNT_W'(shi_pkg::RD_PARAMS)) &&
                 (addr == shi_pkg::ADDR_IRQ_EN || addr == shi_pkg::ADDR_IRQ_STAT);
  assign param_err = exec & ~wr_ok & ~rd_ok;
  assign done      = exec | (state == shi_pkg::S_CODE && pop && is_eof);

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      o_busy <= 1'b0;
    end
    else if (sel_fall)
    begin
      o_busy <= 1'b1;
    end
    else if (done)
    begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      resp       <= '0;
      resp_valid <= 1'b0;
    end
    else if (exec && rd_ok)
    begin
      resp       <= (addr == shi_pkg::ADDR_IRQ_STAT) ? 32'(status) : 32'(enable);
      resp_valid <= 1'b1;
    end
    else if (sel_rise && rd_frame)
    begin
      resp_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= exec & wr_ok & (addr == shi_pkg::ADDR_SYS_CFG) & data[shi_pkg::SOFT_RST_BIT];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      enable <= shi_pkg::EN_RESET;
    end
    else if (exec && wr_ok && addr == shi_pkg::ADDR_IRQ_EN)
    begin
      enable <= data[shi_pkg::NSRC-1:0];
    end
  end

  always_comb
  begin
    set_vec = i_irq_src;
    set_vec[shi_pkg::SRC_GEN_ERR] = i_irq_src[shi_pkg::SRC_GEN_ERR] | param_err | overflow;
    clr_vec = '0;
    if (exec && wr_ok && addr == shi_pkg::ADDR_IRQ_CLR && !i_clr_on_read)
    begin
      clr_vec = data[shi_pkg::NSRC-1:0];
    end
    if (exec && rd_ok && addr == shi_pkg::ADDR_IRQ_STAT && i_clr_on_read)
    begin
      clr_vec = status;
    end
  end

  assign hold = status & ~clr_vec;
  assign pend = |(status & (enable | shi_pkg::NMI_MASK));

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      status <= '0;
    end
    else
    begin
      status <= hold | set_vec;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= i_irq_active_high ? pend : ~pend;
    end
  end

  assign o_irq_status = status;

  a_miso_release: assert property (@(posedge i_clk) disable iff (i_sys_rst) nss |=> !o_miso_oe)
    else $error("data out driven while deselected");
  a_busy_on_select: assert property (@(posedge i_clk) disable iff (rst) sel_fall |=> o_busy)
    else $error("busy not raised at frame start");
  a_flags_sticky: assert property (@(posedge i_clk) disable iff (rst) 1'b1 |=> (status & $past(hold)) == $past(hold))
    else $error("flag lost without clear");
  a_event_recorded: assert property (@(posedge i_clk) disable iff (rst) |set_vec |=> (status & $past(set_vec)) == $past(set_vec))
    else $error("event not recorded");
  a_pin_follows: assert property (@(posedge i_clk) disable iff (rst) pend |=> o_irq == $past(i_irq_active_high))
    else $error("pin not active with enabled flag");
  a_nmi_routes: assert property (@(posedge i_clk) disable iff (rst) |(status & shi_pkg::NMI_MASK) |=> o_irq == $past(i_irq_active_high))
    else $error("unmaskable flag not on pin");
  a_param_error: assert property (@(posedge i_clk) disable iff (rst) param_err |=> status[shi_pkg::SRC_GEN_ERR])
    else $error("parameter error not flagged");
  a_counter_clear: assert property (@(posedge i_clk) disable iff (rst) sel_rise |=> bit_cnt == 3'h0)
    else $error("bit counter not cleared");
  a_resp_ready: assert property (@(posedge i_clk) disable iff (rst) (exec && rd_ok && !sel_fall) |=> resp_valid && !o_busy)
    else $error("read response not ready");
endmodule : shi_host_port

// *** include/shi_pkg.sv ***
package shi_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int MAX_LINK_BPS   = 7_000_000;
  localparam int MIN_SCK_CYC    = CLK_HZ / MAX_LINK_BPS;
  localparam int FIFO_W         = 9;
  localparam int FIFO_D         = 8;
  localparam int EOF_BIT        = 8;
  localparam int MAX_PARAMS     = 260;
  localparam int CNT_W          = 9;
  localparam int WR_PARAMS      = 5;
  localparam int RD_PARAMS      = 1;
  localparam int RESP_BYTES     = 4;
  localparam logic [7:0] CMD_WRITE_REG = 8'h00;
  localparam logic [7:0] CMD_READ_REG  = 8'h04;
  localparam logic [7:0] ADDR_SYS_CFG  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h01;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h02;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h03;
  localparam int SOFT_RST_BIT   = 8;
  localparam int NSRC           = 9;
  localparam int SRC_RX_DONE    = 0;
  localparam int SRC_TX_DONE    = 1;
  localparam int SRC_IDLE       = 2;
  localparam int SRC_TIMER0     = 3;
  localparam int SRC_TIMER1     = 4;
  localparam int SRC_TIMER2     = 5;
  localparam int SRC_CARD_DET   = 6;
  localparam int SRC_GEN_ERR    = 7;
  localparam int SRC_HV_FAULT   = 8;
  localparam logic [NSRC-1:0] NMI_MASK   = 9'h1C0;
  localparam logic [NSRC-1:0] EN_RESET   = 9'h000;
  typedef enum logic [1:0] {
    S_CODE  = 2'b00,
    S_PARAM = 2'b01,
    S_EXEC  = 2'b10
  } shi_state_type;
endpackage : shi_pkg

// *** include/shi_stream_if.sv ***
`timescale 1ns/100ps
interface shi_stream_if #(parameter int W = 9);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : shi_stream_if

// *** tb/shi_host_model.sv ***
`timescale 1ns/100ps
module shi_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  input  wire logic i_busy,
  output logic      o_sck,
  output logic      o_nss,
  output logic      o_mosi
);
  logic last_bit;
  logic saw_busy;
  logic saw_oe;
  // a released line reads back as the inverse of its last value
  wire  miso_w = i_miso_oe ? i_miso : ~last_bit;

  initial
  begin
    o_sck    = 1'b0;
    o_nss    = 1'b1;
    o_mosi   = 1'b0;
    last_bit = 1'b0;
    saw_busy = 1'b0;
    saw_oe   = 1'b0;
  end

  // half period of 4 system clocks (160 ns period), sampled late in the high phase
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      o_mosi <= tx[i];
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      rx[i] = miso_w;
      last_bit = miso_w;
      saw_busy |= i_busy;
      saw_oe |= i_miso_oe;
      @(posedge i_clk);
      o_sck <= 1'b0;
    end
  endtask : shift

  task automatic open_frame();
    saw_busy = 1'b0;
    saw_oe = 1'b0;
    o_nss <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : open_frame

  task automatic close_frame();
    int k;
    k = 0;
    while (i_busy !== 1'b1 && k < 40)
    begin
      @(posedge i_clk);
      k++;
    end
    o_nss <= 1'b1;
    repeat (2) @(posedge i_clk);
    k = 0;
    while (i_busy !== 1'b0 && k < 100)
    begin
      @(posedge i_clk);
      k++;
    end
    repeat (8) @(posedge i_clk);
  endtask : close_frame

  task automatic frame(input logic [7:0] tx [$], output logic [31:0] rx);
    logic [7:0] b;
    rx = 32'h0000_0000;
    open_frame();
    for (int j = 0; j < tx.size(); j++)
    begin
      shift(tx[j], 8, b);
      rx = {b, rx[31:8]};
    end
    close_frame();
  endtask : frame

  // select released in mid-byte on purpose
  task automatic stub(input int nb);
    logic [7:0] b;
    open_frame();
    shift(8'hA5, nb, b);
    close_frame();
  endtask : stub
endmodule : shi_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic                     i_clk;
  logic                     i_sys_rst;
  logic [shi_pkg::NSRC-1:0] i_irq_src;
  logic                     i_clr_on_read;
  logic                     i_irq_active_high;
  logic                     sck;
  logic                     nss;
  logic                     mosi;
  logic                     o_miso;
  logic                     o_miso_oe;
  logic                     o_busy;
  logic                     o_irq;
  logic [shi_pkg::NSRC-1:0] o_irq_status;
  int                       err_count;
  int                       comparisons;
  int                       cycles;
  logic [31:0]              rd;

  shi_host_port dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(sck), .i_nss(nss), .i_mosi(mosi),
    .i_irq_src(i_irq_src), .i_clr_on_read(i_clr_on_read), .i_irq_active_high(i_irq_active_high),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_busy(o_busy), .o_irq(o_irq), .o_irq_status(o_irq_status)
  );
  shi_host_model host (
    .i_clk(i_clk), .i_miso(o_miso), .i_miso_oe(o_miso_oe), .i_busy(o_busy),
    .o_sck(sck), .o_nss(nss), .o_mosi(mosi)
  );

  always #10 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic fr(input logic [7:0] tx [$]);
    host.frame(tx, rd);
    chk(host.saw_busy, 1'b1);
    chk(host.saw_oe, 1'b1);
    chk(o_busy, 1'b0);
    chk(o_miso_oe, 1'b0);
  endtask : fr

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    fr('{shi_pkg::CMD_WRITE_REG, a, v[7:0], v[15:8], v[23:16], v[31:24]});
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    fr('{shi_pkg::CMD_READ_REG, a});
    fr('{8'hFF, 8'hFF, 8'hFF, 8'hFF});
  endtask : rreg

  task automatic pulse(input logic [shi_pkg::NSRC-1:0] m);
    @(posedge i_clk);
    i_irq_src <= m;
    @(posedge i_clk);
    i_irq_src <= '0;
    repeat (4) @(posedge i_clk);
  endtask : pulse

  task automatic t_mask();
    wreg(shi_pkg::ADDR_IRQ_EN, 32'h0000_0003);
    pulse(9'h007);
    chk(o_irq_status, 32'h007);
    chk(o_irq, 1'b1);
    rreg(shi_pkg::ADDR_IRQ_STAT);
    chk(rd, 32'h0000_0007);
    chk(o_irq_status, 32'h007);
    wreg(shi_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    chk(o_irq, 1'b1);
    wreg(shi_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
    chk(o_irq, 1'b0);
    chk(o_irq_status, 32'h004);
    wreg(shi_pkg::ADDR_IRQ_CLR, 32'h0000_0004);
    rreg(shi_pkg::ADDR_IRQ_EN);
    chk(rd, 32'h0000_0003);
    wreg(shi_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    $display("t_mask done");
  endtask : t_mask

  task automatic t_nmi();
    for (int s = 6; s < 9; s++)
    begin
      i_irq_active_high <= (s != 7);
      pulse(9'h001 << s);
      chk(o_irq_status, 32'h1 << s);
      chk(o_irq, s != 7);
      wreg(shi_pkg::ADDR_IRQ_CLR, 32'h1 << s);
      chk(o_irq, s == 7);
    end
    i_irq_active_high <= 1'b1;
    $display("t_nmi done");
  endtask : t_nmi

  task automatic bad(input logic [7:0] tx [$]);
    fr(tx);
    chk(o_irq_status, 32'h080);
    chk(o_irq, 1'b1);
    wreg(shi_pkg::ADDR_IRQ_CLR, 32'h0000_0080);
    chk(o_irq_status, 32'h000);
  endtask : bad

  task automatic t_err();
    bad('{8'h09, 8'h00});
    bad('{shi_pkg::CMD_WRITE_REG, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04});
    bad('{shi_pkg::CMD_READ_REG});
    $display("t_err done");
  endtask : t_err

  task automatic t_clr_read();
    i_clr_on_read <= 1'b1;
    pulse(9'h001);
    wreg(shi_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    chk(o_irq_status, 32'h001);
    rreg(shi_pkg::ADDR_IRQ_STAT);
    chk(rd, 32'h0000_0001);
    chk(o_irq_status, 32'h000);
    i_clr_on_read <= 1'b0;
    $display("t_clr_read done");
  endtask : t_clr_read

  task automatic t_partial();
    host.stub(3);
    wreg(shi_pkg::ADDR_IRQ_EN, 32'h0000_0155);
    rreg(shi_pkg::ADDR_IRQ_EN);
    chk(rd, 32'h0000_0155);
    pulse(9'h001);
    wreg(shi_pkg::ADDR_SYS_CFG, 32'h0000_0100);
    chk(o_irq_status, 32'h000);
    rreg(shi_pkg::ADDR_IRQ_EN);
    chk(rd, 32'h0000_0000);
    $display("t_partial done");
  endtask : t_partial

  initial
  begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_irq_src = '0;
    i_clr_on_read = 1'b0;
    i_irq_active_high = 1'b1;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk(o_busy, 1'b0);
    chk(o_miso_oe, 1'b0);
    chk(o_irq_status, 32'h000);
    chk(o_irq, 1'b0);
    $display("t_reset done");
    t_mask();
    t_nmi();
    t_err();
    t_clr_read();
    t_partial();
    close_out();
  end
endmodule : tb_top
